// *** bench/mit_core_model.sv ***
// Core stand-in: one-deep return stack, running pc, return strobes
module mit_core_model #(parameter PC_W = 13) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Bench commands
    input wire do_ret,
    input wire do_return_from_interrupt,
    // Block side
    input wire irq_take,
    input wire [PC_W-1:0] push_pc,
    output reg [PC_W-1:0] core_pc,
    output reg stack_full,
    output reg core_ready,
    output reg return_plain,
    output reg return_from_interrupt,
    output reg [PC_W-1:0] popped_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [PC_W-1:0] stack_reg;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_pc <= 0;
            stack_full <= 0;
            core_ready <= 0;
            return_plain <= 0;
            return_from_interrupt <= 0;
            popped_pc <= 0;
            stack_reg <= 0;
        end else begin
            core_pc <= core_pc + 1'b1;
            // Busy in the cycle after a return, as a real core is
            core_ready <= !(do_ret || do_return_from_interrupt);
            return_plain <= do_ret && stack_full;
            return_from_interrupt <= do_return_from_interrupt && stack_full;
            // Empty stack shows a changing value, not the last one
            popped_pc <= stack_full ? stack_reg : ~popped_pc;
            if (irq_take) begin
                stack_reg <= push_pc;
                stack_full <= 1'b1;
            end else if ((do_ret || do_return_from_interrupt) && stack_full) begin
                stack_full <= 1'b0;
            end
        end
    end
endmodule

// *** bench/mit_irq_ctrl_chk.sv ***
// Port timing checker of the interrupt block
module mit_irq_ctrl_chk #(parameter PC_W = 13) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // Core side
    input wire stack_full,
    input wire core_ready,
    input wire [PC_W-1:0] core_pc,
    input wire return_plain,
    input wire return_from_interrupt,
    input wire [PC_W-1:0] popped_pc,
    input wire low_power,
    input wire irq_take,
    input wire [2:0] irq_vector,
    input wire [PC_W-1:0] push_pc,
    input wire pc_restore,
    input wire [PC_W-1:0] restore_pc,
    input wire wake_up
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_ret;
        return_plain || return_from_interrupt;
    endsequence
    a_bus_answer: assert property (s_req |=> s_ans)
        else $error("bus answer out of step");
    a_take_room: assert property (irq_take |-> !$past(stack_full) && $past(core_ready))
        else $error("take while stack full");
    a_push_pc: assert property (irq_take |-> push_pc == $past(core_pc))
        else $error("wrong pushed pc");
    a_vec_range: assert property (irq_take |-> irq_vector inside {[1:6]})
        else $error("bad vector");
    a_take_single: assert property (irq_take |=> !irq_take)
        else $error("take not blocked");
    a_ret_restore: assert property (s_ret |=> pc_restore && restore_pc == $past(popped_pc))
        else $error("restore missing");
    a_restore_cause: assert property (pc_restore |-> $past(return_plain) || $past(return_from_interrupt))
        else $error("restore without return");
    a_wake_sleep: assert property (wake_up |-> $past(low_power) || $past(low_power, 2))
        else $error("wake while awake");
    a_vec_hold: assert property (!irq_take |-> $stable(irq_vector))
        else $error("vector moved without take");
endmodule

bind mit_irq_ctrl mit_irq_ctrl_chk #(.PC_W(PC_W)) u_chk (.ref_clk, .reset_n, .avs_read, .avs_write,
    .avs_waitrequest, .stack_full, .core_ready, .core_pc, .return_plain, .return_from_interrupt,
    .popped_pc, .low_power, .irq_take, .irq_vector, .push_pc, .pc_restore, .restore_pc, .wake_up);

// *** bench/mit_irq_ctrl_tb.sv ***
// Self-checking bench of the interrupt and time base block
module mit_irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, avs_read, avs_write, conv_done, nvm_write_done;
    logic low_power, do_ret, do_return_from_interrupt;
    logic tick_clk_en = 0;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata;
    logic [1:0] timer_cmp_p_match, timer_cmp_a_match;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, stack_full, core_ready, return_plain, return_from_interrupt;
    wire irq_take, pc_restore, wake_up;
    wire [2:0] irq_vector;
    wire [12:0] core_pc, push_pc, popped_pc, restore_pc;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int takes = 0;
    int wakes = 0;
    int t_take, t0, n;
    mit_irq_ctrl dut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .conv_done, .nvm_write_done, .timer_cmp_p_match,
        .timer_cmp_a_match, .tick_clk_en, .stack_full, .core_ready, .core_pc, .return_plain,
        .return_from_interrupt, .popped_pc, .low_power, .irq_take, .irq_vector, .push_pc,
        .pc_restore, .restore_pc, .wake_up);
    mit_core_model core (.ref_clk, .reset_n, .do_ret, .do_return_from_interrupt, .irq_take, .push_pc, .core_pc,
        .stack_full, .core_ready, .return_plain, .return_from_interrupt, .popped_pc);
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Tick clock at half rate; counters of takes and wakes
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        tick_clk_en <= !tick_clk_en;
        if (irq_take === 1'b1) takes <= takes + 1;
        if (wake_up === 1'b1) wakes <= wakes + 1;
        if (cyc == 60000) begin
            mismatches++;
            final_report;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(0, a, 0, q);
        chk(q, exp);
    endtask
    // Event pulses: conv, nvm, timer P matches, timer A matches
    task automatic ev(input logic [5:0] m);
        {conv_done, nvm_write_done, timer_cmp_p_match, timer_cmp_a_match} <= m;
        @(posedge ref_clk);
        {conv_done, nvm_write_done, timer_cmp_p_match, timer_cmp_a_match} <= 6'h0;
        @(posedge ref_clk);
    endtask
    task automatic take(input logic [2:0] v);
        int k;
        k = 0;
        while (irq_take !== 1'b1 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        t_take = cyc;
        chk(irq_take, 1'b1);
        chk(irq_vector, v);
        @(posedge ref_clk);
    endtask
    task automatic ret(input logic i);
        do_return_from_interrupt <= i;
        do_ret <= !i;
        @(posedge ref_clk);
        {do_ret, do_return_from_interrupt} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic t_regs;
        rd(0, 32'h37);
        rd(1, 32'h0);
        wr(0, 32'hff);
        rd(0, 32'hf7);
        rd(4'h5, 32'h0);
        wr(0, 32'h0);
    endtask
    task automatic t_conv;
        wr(1, 32'h3);
        ev(6'h20);
        take(1);
        rd(1, 32'h2);
        ret(1);
        rd(1, 32'h3);
        ev(6'h20);
        take(1);
        ret(0);
        rd(1, 32'h2);
    endtask
    task automatic t_prio;
        ev(6'h30);
        rd(1, 32'h902);
        wr(1, 32'h913);
        take(1);
        rd(1, 32'h812);
        ret(1);
        take(4);
        rd(1, 32'h12);
        rd(3, 32'h4);
        ret(1);
    endtask
    task automatic t_stack;
        wr(1, 32'h3);
        ev(6'h20);
        take(1);
        wr(1, 32'h3);
        ev(6'h20);
        n = takes;
        repeat (20) @(posedge ref_clk);
        chk(takes - n, 0);
        ret(0);
        take(1);
        ret(1);
    endtask
    task automatic t_grp;
        wr(2, 32'h21);
        wr(1, 32'h61);
        ev(6'h06);
        take(5);
        rd(1, 32'h2060);
        rd(2, 32'h2121);
        ret(1);
        take(6);
        rd(1, 32'h60);
        wr(2, 32'h21);
        rd(2, 32'h21);
        ret(1);
    endtask
    task automatic t_tick;
        wr(1, 32'h5);
        wr(0, 32'hc0);
        take(2);
        t0 = t_take;
        ret(1);
        take(2);
        chk(t_take - t0, 1024);
        rd(1, 32'h4);
        ret(1);
        wr(0, 32'h0);
        wr(1, 32'h9);
        wr(0, 32'h80);
        take(3);
        t0 = t_take;
        ret(1);
        take(3);
        chk(t_take - t0, 8192);
        ret(1);
        wr(0, 32'h0);
        wr(1, 32'h0);
        repeat (600) @(posedge ref_clk);
        rd(1, 32'h0);
    endtask
    task automatic t_wake;
        wr(1, 32'h100);
        low_power <= 1;
        n = wakes;
        ev(6'h10);
        repeat (3) @(posedge ref_clk);
        chk(wakes - n, 1);
        ev(6'h20);
        ev(6'h10);
        repeat (3) @(posedge ref_clk);
        chk(wakes - n, 1);
        low_power <= 0;
    endtask
    initial begin
        reset_n = 0;
        {avs_read, avs_write, conv_done, nvm_write_done, low_power, do_ret, do_return_from_interrupt} = 7'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        timer_cmp_p_match = 2'h0;
        timer_cmp_a_match = 2'h0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1;
        @(posedge ref_clk);
        t_regs;
        t_conv;
        t_prio;
        t_stack;
        t_grp;
        t_tick;
        t_wake;
        final_report;
    end
endmodule

// *** verilog/mit_irq_ctrl.v ***
// Interrupt request, vectoring and time base control for the small CPU core
`include "mit_map.vh"
module mit_irq_ctrl #(
    parameter NUM_TIMERS = 2,
    parameter PC_W = 13
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Event sources
    input wire conv_done,
    input wire nvm_write_done,
    input wire [NUM_TIMERS-1:0] timer_cmp_p_match,
    input wire [NUM_TIMERS-1:0] timer_cmp_a_match,
    input wire tick_clk_en,
    // Core handshake
    input wire stack_full,
    input wire core_ready,
    input wire [PC_W-1:0] core_pc,
    input wire return_plain,
    input wire return_from_interrupt,
    input wire [PC_W-1:0] popped_pc,
    input wire low_power,
    output reg irq_take,
    output reg [2:0] irq_vector,
    output reg [PC_W-1:0] push_pc,
    output reg pc_restore,
    output reg [PC_W-1:0] restore_pc,
    output reg wake_up
);
    // Register state
    reg [7:0] time_base_control_reg;
    reg global_irq_enable_reg;
    reg conv_done_irq_enable_reg;
    reg tick0_irq_enable_reg;
    reg tick1_irq_enable_reg;
    reg nvm_write_done_enable_reg;
    reg [1:0] group_enable_reg;
    reg conv_done_req_flag_reg;
    reg tick0_req_flag_reg;
    reg tick1_req_flag_reg;
    reg nvm_write_done_flag_reg;
    reg [1:0] group_irq_flag_reg;
    reg [NUM_TIMERS-1:0] timer_cmp_p_flag_reg;
    reg [NUM_TIMERS-1:0] timer_cmp_a_flag_reg;
    reg [NUM_TIMERS-1:0] timer_cmp_p_enable_reg;
    reg [NUM_TIMERS-1:0] timer_cmp_a_enable_reg;
    reg [1:0] sys_div_reg;
    reg [5:0] flags_last_reg;
    reg [2*NUM_TIMERS-1:0] tflags_last_reg;

    // Bus decode
    function mit_hit;
        input [3:0] addr;
        input [3:0] off;
        begin
            mit_hit = addr == off;
        end
    endfunction

    // Writes land only at the answering edge, never while waiting
    wire wr_ok = avs_write && !avs_waitrequest;
    wire wr_tbc = wr_ok && mit_hit(avs_address, `MIT_OFF_TBC);
    wire wr_intc = wr_ok && mit_hit(avs_address, `MIT_OFF_INTC);
    wire wr_tmr = wr_ok && mit_hit(avs_address, `MIT_OFF_TMR);

    // Tick source select
    wire sys_quarter = sys_div_reg == `MIT_SYS_DIV;
    wire tick_in = time_base_control_reg[`MIT_TBC_CK] ? sys_quarter : tick_clk_en;
    wire tb0_ovf;
    wire tb1_ovf;

    // Divider restarts from zero whenever it is switched off
    mit_tick_div u_div (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(time_base_control_reg[`MIT_TBC_ON]),
        .tick_in(tick_in),
        .sel0(time_base_control_reg[`MIT_TBC_P0_HI:`MIT_TBC_P0_LO]),
        .sel1(time_base_control_reg[`MIT_TBC_P1_HI:`MIT_TBC_P1_LO]),
        .ovf0(tb0_ovf),
        .ovf1(tb1_ovf)
    );

    // Timer compare requests, grouped by lower and upper half of the timers
    wire [NUM_TIMERS-1:0] tm_req = (timer_cmp_p_flag_reg & timer_cmp_p_enable_reg) |
                                   (timer_cmp_a_flag_reg & timer_cmp_a_enable_reg);
    wire [NUM_TIMERS-1:0] tm_set = timer_cmp_p_match | timer_cmp_a_match;
    wire [1:0] grp_req;
    wire [1:0] grp_set;
    assign grp_req[0] = |tm_req[NUM_TIMERS/2-1:0];
    assign grp_req[1] = |tm_req[NUM_TIMERS-1:NUM_TIMERS/2];
    assign grp_set[0] = |tm_set[NUM_TIMERS/2-1:0];
    assign grp_set[1] = |tm_set[NUM_TIMERS-1:NUM_TIMERS/2];

    // Source slots, highest priority first
    localparam SRC_CONV = 0;
    localparam SRC_TICK0 = 1;
    localparam SRC_TICK1 = 2;
    localparam SRC_NVM = 3;
    localparam SRC_GRP0 = 4;
    localparam SRC_GRP1 = 5;

    // Pending enabled sources
    wire [5:0] pend;
    assign pend[SRC_CONV] = conv_done_req_flag_reg && conv_done_irq_enable_reg;
    assign pend[SRC_TICK0] = tick0_req_flag_reg && tick0_irq_enable_reg;
    assign pend[SRC_TICK1] = tick1_req_flag_reg && tick1_irq_enable_reg;
    assign pend[SRC_NVM] = nvm_write_done_flag_reg && nvm_write_done_enable_reg;
    assign pend[SRC_GRP0] = group_irq_flag_reg[0] && group_enable_reg[0] && grp_req[0];
    assign pend[SRC_GRP1] = group_irq_flag_reg[1] && group_enable_reg[1] && grp_req[1];

    // Highest priority index, lowest bit first
    function [2:0] mit_pick;
        input [5:0] p;
        integer i;
        begin
            mit_pick = 3'd7;
            for (i = 5; i >= 0; i = i - 1) begin
                if (p[i]) begin
                    mit_pick = i[2:0];
                end
            end
        end
    endfunction

    wire [2:0] win = mit_pick(pend);
    // Stack room gates acknowledge; core must pop before next take
    wire take = global_irq_enable_reg && (|pend) && !stack_full && core_ready && !irq_take;
    wire [5:0] svc = take ? (6'h01 << win) : 6'h00;

    // Hardware set beats software clear
    function set_clr;
        input cur;
        input set;
        input wclr;
        input wval;
        input hclr;
        begin
            set_clr = set | (cur & ~hclr & ~(wclr & ~wval)) | (wclr & wval);
        end
    endfunction

    // Free running quarter-rate strobe from the system clock
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_div_reg <= 2'd0;
        end else begin
            sys_div_reg <= sys_div_reg + 2'd1;
        end
    end

    // Control and flags
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            time_base_control_reg <= `MIT_TBC_RESET;
            global_irq_enable_reg <= 1'b0;
            conv_done_irq_enable_reg <= 1'b0;
            tick0_irq_enable_reg <= 1'b0;
            tick1_irq_enable_reg <= 1'b0;
            nvm_write_done_enable_reg <= 1'b0;
            group_enable_reg <= 2'b00;
            conv_done_req_flag_reg <= 1'b0;
            tick0_req_flag_reg <= 1'b0;
            tick1_req_flag_reg <= 1'b0;
            nvm_write_done_flag_reg <= 1'b0;
            group_irq_flag_reg <= 2'b00;
        end else begin
            if (wr_tbc) begin
                time_base_control_reg <= avs_writedata[7:0] & `MIT_TBC_MASK;
            end
            if (take) begin
                global_irq_enable_reg <= 1'b0;
            end else if (return_from_interrupt) begin
                global_irq_enable_reg <= 1'b1;
            end else if (wr_intc) begin
                global_irq_enable_reg <= avs_writedata[`MIT_IC_GIE];
            end
            if (wr_intc) begin
                conv_done_irq_enable_reg <= avs_writedata[`MIT_IC_ADE];
                tick0_irq_enable_reg <= avs_writedata[`MIT_IC_TICK0_IRQ_ENABLE];
                tick1_irq_enable_reg <= avs_writedata[`MIT_IC_TICK1_IRQ_ENABLE];
                nvm_write_done_enable_reg <= avs_writedata[`MIT_IC_DEE];
                group_enable_reg <= avs_writedata[`MIT_IC_MF1E:`MIT_IC_MF0E];
            end
            conv_done_req_flag_reg <= set_clr(conv_done_req_flag_reg, conv_done, wr_intc,
                avs_writedata[`MIT_IC_ADF], svc[0]);
            tick0_req_flag_reg <= set_clr(tick0_req_flag_reg, tb0_ovf, wr_intc,
                avs_writedata[`MIT_IC_TICK0_REQ_FLAG], svc[1]);
            tick1_req_flag_reg <= set_clr(tick1_req_flag_reg, tb1_ovf, wr_intc,
                avs_writedata[`MIT_IC_TICK1_REQ_FLAG], svc[2]);
            nvm_write_done_flag_reg <= set_clr(nvm_write_done_flag_reg, nvm_write_done, wr_intc,
                avs_writedata[`MIT_IC_DEF], svc[3]);
            group_irq_flag_reg[0] <= set_clr(group_irq_flag_reg[0], grp_set[0], wr_intc,
                avs_writedata[`MIT_IC_MF0F], svc[4]);
            group_irq_flag_reg[1] <= set_clr(group_irq_flag_reg[1], grp_set[1], wr_intc,
                avs_writedata[`MIT_IC_MF1F], svc[5]);
        end
    end

    // Per timer flags, cleared only by software
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g = g + 1) begin : g_tm
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    timer_cmp_p_flag_reg[g] <= 1'b0;
                    timer_cmp_a_flag_reg[g] <= 1'b0;
                    timer_cmp_p_enable_reg[g] <= 1'b0;
                    timer_cmp_a_enable_reg[g] <= 1'b0;
                end else begin
                    timer_cmp_p_flag_reg[g] <= set_clr(timer_cmp_p_flag_reg[g], timer_cmp_p_match[g],
                        wr_tmr, avs_writedata[8+4*g], 1'b0);
                    timer_cmp_a_flag_reg[g] <= set_clr(timer_cmp_a_flag_reg[g], timer_cmp_a_match[g],
                        wr_tmr, avs_writedata[9+4*g], 1'b0);
                    if (wr_tmr) begin
                        timer_cmp_p_enable_reg[g] <= avs_writedata[4*g];
                        timer_cmp_a_enable_reg[g] <= avs_writedata[1+4*g];
                    end
                end
            end
        end
    endgenerate

    wire [5:0] flags_now = {group_irq_flag_reg, nvm_write_done_flag_reg, tick1_req_flag_reg,
        tick0_req_flag_reg, conv_done_req_flag_reg};
    wire [2*NUM_TIMERS-1:0] tflags_now = {timer_cmp_a_flag_reg, timer_cmp_p_flag_reg};
    // Last-seen copies reset low, the idle level of every flag
    wire rise = (|(flags_now & ~flags_last_reg)) || (|(tflags_now & ~tflags_last_reg));

    // Core side outputs and wake detect
    // Vector is one based; zero means none taken yet
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_last_reg <= 6'h00;
            tflags_last_reg <= {2*NUM_TIMERS{1'b0}};
            wake_up <= 1'b0;
            irq_take <= 1'b0;
            irq_vector <= 3'd0;
            push_pc <= {PC_W{1'b0}};
            pc_restore <= 1'b0;
            restore_pc <= {PC_W{1'b0}};
        end else begin
            flags_last_reg <= flags_now;
            tflags_last_reg <= tflags_now;
            // Enables play no part; only a fresh rising edge wakes
            wake_up <= low_power && rise;
            irq_take <= take;
            if (take) begin
                irq_vector <= win + 3'd1;
                push_pc <= core_pc;
            end
            pc_restore <= return_plain || return_from_interrupt;
            if (return_plain || return_from_interrupt) begin
                restore_pc <= popped_pc;
            end
        end
    end

    // Bus read mux
    // Flags read back from their registers, so a set in the capture cycle shows on the next poll
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `MIT_OFF_TBC: rd_mux[7:0] = time_base_control_reg;
            `MIT_OFF_INTC: begin
                rd_mux[`MIT_IC_GIE] = global_irq_enable_reg;
                rd_mux[`MIT_IC_ADE] = conv_done_irq_enable_reg;
                rd_mux[`MIT_IC_TICK0_IRQ_ENABLE] = tick0_irq_enable_reg;
                rd_mux[`MIT_IC_TICK1_IRQ_ENABLE] = tick1_irq_enable_reg;
                rd_mux[`MIT_IC_DEE] = nvm_write_done_enable_reg;
                rd_mux[`MIT_IC_MF1E:`MIT_IC_MF0E] = group_enable_reg;
                rd_mux[`MIT_IC_MF1F:`MIT_IC_ADF] = flags_now;
            end
            `MIT_OFF_TMR: rd_mux = mit_tmr_pack(timer_cmp_p_enable_reg, timer_cmp_a_enable_reg,
                timer_cmp_p_flag_reg, timer_cmp_a_flag_reg);
            `MIT_OFF_STAT: rd_mux[2:0] = irq_vector;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    function [31:0] mit_tmr_pack;
        input [NUM_TIMERS-1:0] pe;
        input [NUM_TIMERS-1:0] ae;
        input [NUM_TIMERS-1:0] pf;
        input [NUM_TIMERS-1:0] af;
        integer k;
        begin
            mit_tmr_pack = 32'h0000_0000;
            for (k = 0; k < NUM_TIMERS; k = k + 1) begin
                mit_tmr_pack[4*k] = pe[k];
                mit_tmr_pack[4*k+1] = ae[k];
                mit_tmr_pack[4*k+8] = pf[k];
                mit_tmr_pack[4*k+9] = af[k];
            end
        end
    endfunction

    // One wait cycle per access, then answer
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end
endmodule

// *** verilog/mit_map.vh ***
// Register offsets, field positions, reset values and timing counts of the interrupt block
`ifndef MIT_MAP_VH
`define MIT_MAP_VH

// Register word offsets, one address per register
`define MIT_OFF_TBC 4'h0
`define MIT_OFF_INTC 4'h1
`define MIT_OFF_TMR 4'h2
`define MIT_OFF_STAT 4'h3

// Time base control fields
`define MIT_TBC_ON 7
`define MIT_TBC_CK 6
`define MIT_TBC_P1_HI 5
`define MIT_TBC_P1_LO 4
`define MIT_TBC_P0_HI 2
`define MIT_TBC_P0_LO 0
`define MIT_TBC_RESET 8'h37
`define MIT_TBC_MASK 8'hf7

// Interrupt control fields
`define MIT_IC_GIE 0
`define MIT_IC_ADE 1
`define MIT_IC_TICK0_IRQ_ENABLE 2
`define MIT_IC_TICK1_IRQ_ENABLE 3
`define MIT_IC_DEE 4
`define MIT_IC_MF0E 5
`define MIT_IC_MF1E 6
`define MIT_IC_ADF 8
`define MIT_IC_TICK0_REQ_FLAG 9
`define MIT_IC_TICK1_REQ_FLAG 10
`define MIT_IC_DEF 11
`define MIT_IC_MF0F 12
`define MIT_IC_MF1F 13

// Shortest divider periods, in input clocks
`define MIT_TB0_MIN 256
`define MIT_TB1_MIN 4096
`define MIT_SYS_DIV 2'd3

// Vector numbers in priority order
`define MIT_VEC_ADC 3'd1
`define MIT_VEC_TB0 3'd2
`define MIT_VEC_TB1 3'd3
`define MIT_VEC_NVM 3'd4
`define MIT_VEC_MF0 3'd5
`define MIT_VEC_MF1 3'd6

`endif

// *** verilog/mit_tick_div.v ***
// Time base divider: free counter with two selectable overflow taps
`include "mit_map.vh"
module mit_tick_div (
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Control
    input wire run,
    input wire tick_in,
    input wire [2:0] sel0,
    input wire [1:0] sel1,
    // Overflow strobes
    output reg ovf0,
    output reg ovf1
);
    reg [14:0] count_reg;
    wire [14:0] count_next = count_reg + 15'h0001;
    wire [3:0] tap0 = {1'b0, sel0} + 4'h7;
    wire [3:0] tap1 = {2'b00, sel1} + 4'hb;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 15'h0000;
            ovf0 <= 1'b0;
            ovf1 <= 1'b0;
        end else if (!run) begin
            // Stopped dividers restart from zero
            count_reg <= 15'h0000;
            ovf0 <= 1'b0;
            ovf1 <= 1'b0;
        end else begin
            count_reg <= tick_in ? count_next : count_reg;
            // Overflow when the tap bit rises, every second roll-over of the bits below
            ovf0 <= tick_in && count_next[tap0] && !count_reg[tap0];
            ovf1 <= tick_in && count_next[tap1] && !count_reg[tap1];
        end
    end
endmodule
